//--- uoe_map.svh
// Offsets, field positions, reset values and timing counts of the OTG event flags.
// Assumes a 250 MHz core clock and byte addressing on the register bus.
`ifndef UOE_MAP_SVH
`define UOE_MAP_SVH

`define UOE_ADDR_W       4
`define UOE_STATUS_OFS   4'h0
`define UOE_MASK_OFS     4'h4

`define UOE_BIT_ID       7
`define UOE_BIT_TICK     6
`define UOE_BIT_LINE     5
`define UOE_BIT_ACT      4
`define UOE_BIT_SESVD    3
`define UOE_BIT_SESEND   2
`define UOE_BIT_RSVD     1
`define UOE_BIT_VBUSVD   0

`define UOE_IMPL_MASK    8'hFD
`define UOE_FLAGS_RST    8'h00
`define UOE_MASK_RST     8'h00
`define UOE_LINE_RST     2'h0

`define UOE_CLK_NS       4
`define UOE_MS_NS        1000000
`define UOE_MS_CYC       (`UOE_MS_NS / `UOE_CLK_NS)
`define UOE_CNT_W        18

`endif

//--- uoe_pkg.sv
// Types shared by the OTG event flag block.
// Assumes uoe_map.svh is on the include path.
package uoe_pkg;

    typedef struct packed {
        logic id;
        logic tick;
        logic line;
        logic act;
        logic sesvd;
        logic sesend;
        logic rsvd;
        logic vbusvd;
    } uoe_flags_t;

    typedef struct packed {
        logic id;
        logic dp;
        logic dm;
        logic sess_valid;
        logic sess_end;
    } uoe_pins_t;

    typedef struct packed {
        logic [3:0]  address;
        logic        read;
        logic        write;
        logic [31:0] writedata;
        logic [3:0]  byteenable;
    } uoe_avm_req_t;

    typedef enum logic {
        UOE_IDLE = 1'b0,
        UOE_ACK  = 1'b1
    } uoe_bus_state_t;

endpackage : uoe_pkg

//--- uoe_event_flags.sv
// OTG event flag register with mask, one interrupt line and Avalon-MM slave.
// Assumes transceiver and comparator pins are asynchronous; sleep_en is on clk.
`include "uoe_map.svh"

module uoe_event_flags
    import uoe_pkg::*;
#(
    parameter int unsigned MS_CYCLES = `UOE_MS_CYC
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire uoe_pins_t    pins,
    input  wire logic         sleep_en,
    input  wire uoe_avm_req_t avm_req,
    output logic [31:0]       avm_readdata,
    output logic              avm_waitrequest,
    output logic              irq
);

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic addr_hit(input logic [3:0] addr, input logic [3:0] ofs);
        addr_hit = (addr[3:2] == ofs[3:2]);
    endfunction : addr_hit

    function automatic logic edge_seen(input logic now_v, input logic old_v);
        edge_seen = (now_v != old_v);
    endfunction : edge_seen

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    localparam logic [`UOE_CNT_W-1:0] MS_LAST = `UOE_CNT_W'(MS_CYCLES - 1);

    uoe_pins_t             sync1_r;
    uoe_pins_t             sync2_r;
    uoe_pins_t             prev_r;
    uoe_flags_t            flags_r;
    uoe_flags_t            flags_nxt;
    uoe_flags_t            set_ev;
    uoe_flags_t            clr_ev;
    logic [7:0]            mask_r;
    logic [`UOE_CNT_W-1:0] tick_cnt_r;
    logic                  tick_pulse;
    logic [1:0]            line_now;
    logic [1:0]            line_cand_r;
    logic [1:0]            line_stable_r;
    logic [`UOE_CNT_W-1:0] line_cnt_r;
    logic                  line_ev;
    logic                  act_ev;
    uoe_bus_state_t        bus_state_r;
    logic                  bus_req;
    logic                  bus_acc;
    logic                  wr_status;
    logic                  wr_mask;
    logic [`UOE_CNT_W-1:0] tick_gap_r;
    logic [`UOE_CNT_W-1:0] line_held_r;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; only the second stage feeds logic

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= pins;
            sync2_r <= sync1_r;
        end
    end

    // Previous synchronised value, for change detection
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_r <= '0;
        end else begin
            prev_r <= sync2_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // One millisecond interval timer, free running from reset

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt_r <= '0;
        end else if (tick_cnt_r == MS_LAST) begin
            tick_cnt_r <= '0;
        end else begin
            tick_cnt_r <= tick_cnt_r + `UOE_CNT_W'(1);
        end
    end

    assign tick_pulse = (tick_cnt_r == MS_LAST);

    ////////////////////////////////////////////////////////////////////////
    // Line state stability detector

    assign line_now = {sync2_r.dp, sync2_r.dm};

    // Counter saturates at the last count so one stable period fires once
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            line_cand_r <= `UOE_LINE_RST;
            line_cnt_r  <= '0;
        end else if (line_now != line_cand_r) begin
            line_cand_r <= line_now;
            line_cnt_r  <= '0;
        end else if (line_cnt_r != MS_LAST) begin
            line_cnt_r <= line_cnt_r + `UOE_CNT_W'(1);
        end
    end

    assign line_ev = (line_now == line_cand_r) && (line_cnt_r == MS_LAST - `UOE_CNT_W'(1))
                     && (line_cand_r != line_stable_r);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            line_stable_r <= `UOE_LINE_RST;
        end else if (line_ev) begin
            line_stable_r <= line_cand_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Wake-up activity: only counts while the device sleeps

    assign act_ev = sleep_en && (edge_seen(sync2_r.dp, prev_r.dp)
                              || edge_seen(sync2_r.dm, prev_r.dm)
                              || edge_seen(sync2_r.id, prev_r.id)
                              || edge_seen(sync2_r.sess_valid, prev_r.sess_valid)
                              || edge_seen(sync2_r.sess_end, prev_r.sess_end));

    ////////////////////////////////////////////////////////////////////////
    // Event collection

    always_comb begin
        set_ev        = '0;
        set_ev.id     = edge_seen(sync2_r.id, prev_r.id);
        set_ev.tick   = tick_pulse;
        set_ev.line   = line_ev;
        set_ev.act    = act_ev;
        set_ev.sesvd  = sync2_r.sess_end && !prev_r.sess_end;
        set_ev.sesend = edge_seen(sync2_r.sess_end, prev_r.sess_end);
        set_ev.vbusvd = edge_seen(sync2_r.sess_valid, prev_r.sess_valid);
    end

    ////////////////////////////////////////////////////////////////////////
    // Avalon-MM slave: one wait cycle, then accept

    assign bus_req   = avm_req.read || avm_req.write;
    assign bus_acc   = bus_req && (bus_state_r == UOE_ACK);
    assign wr_status = bus_acc && avm_req.write && avm_req.byteenable[0]
                       && addr_hit(avm_req.address, `UOE_STATUS_OFS);
    assign wr_mask   = bus_acc && avm_req.write && avm_req.byteenable[0]
                       && addr_hit(avm_req.address, `UOE_MASK_OFS);

    assign avm_waitrequest = bus_req && (bus_state_r == UOE_IDLE);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_state_r <= UOE_IDLE;
        end else begin
            unique case (bus_state_r)
                UOE_IDLE: begin
                    if (bus_req) begin
                        bus_state_r <= UOE_ACK;
                    end
                end
                UOE_ACK: begin
                    bus_state_r <= UOE_IDLE;
                end
            endcase
        end
    end

    // Read data is loaded during the wait cycle so it stands at the accept edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            avm_readdata <= 32'h0000_0000;
        end else if (avm_req.read && bus_state_r == UOE_IDLE) begin
            if (addr_hit(avm_req.address, `UOE_STATUS_OFS)) begin
                avm_readdata <= {24'h00_0000, 8'(flags_r) & `UOE_IMPL_MASK};
            end else if (addr_hit(avm_req.address, `UOE_MASK_OFS)) begin
                avm_readdata <= {24'h00_0000, mask_r};
            end else begin
                avm_readdata <= 32'h0000_0000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sticky flags; set wins over a same-cycle clear

    always_comb begin
        clr_ev    = wr_status ? uoe_flags_t'(avm_req.writedata[7:0]) : uoe_flags_t'(8'h00);
        flags_nxt = uoe_flags_t'(((8'(flags_r) & ~8'(clr_ev)) | 8'(set_ev)) & `UOE_IMPL_MASK);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flags_r <= uoe_flags_t'(`UOE_FLAGS_RST);
        end else begin
            flags_r <= flags_nxt;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mask_r <= `UOE_MASK_RST;
        end else if (wr_mask) begin
            mask_r <= avm_req.writedata[7:0] & `UOE_IMPL_MASK;
        end
    end

    // Level interrupt; software must clear the flag or its mask bit to drop it
    assign irq = |(8'(flags_r) & mask_r);

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    id_flag_set_a: assert property ($changed(sync2_r.id) |=> flags_r.id)
        else $error("ID change did not set its flag");

    tick_period_a: assert property (tick_pulse |=> !tick_pulse [*8])
        else $error("Timer expired twice too close together");

    tick_flag_set_a: assert property (tick_pulse |=> flags_r.tick)
        else $error("Timer expiry did not set its flag");

    line_flag_cause_a: assert property ($rose(flags_r.line) |-> $past(line_ev)
                                        && $past(line_cand_r) != $past(line_stable_r))
        else $error("Line flag rose without a new stable state");

    act_flag_sleep_a: assert property ($rose(flags_r.act) |-> $past(sleep_en))
        else $error("Activity flag rose while awake");

    sesvd_flag_set_a: assert property ($rose(sync2_r.sess_end) |=> flags_r.sesvd)
        else $error("Drop below session end did not set its flag");

    sesend_flag_set_a: assert property ($changed(sync2_r.sess_end) |=> flags_r.sesend)
        else $error("Session end change did not set its flag");

    vbusvd_flag_set_a: assert property ($changed(sync2_r.sess_valid) |=> flags_r.vbusvd)
        else $error("Session valid change did not set its flag");

    w1c_clear_a: assert property (wr_status && set_ev == '0
                                  |=> 8'(flags_r) == (8'($past(flags_r)) & ~$past(avm_req.writedata[7:0])))
        else $error("Write one to clear misbehaved");

    rsvd_zero_a: assert property (!bus_acc || avm_readdata[31:8] == 24'h00_0000
                                  && (!addr_hit(avm_req.address, `UOE_STATUS_OFS) || !avm_readdata[1]))
        else $error("Unimplemented status bits read as one");

    set_wins_a: assert property (wr_status && (8'(set_ev) & `UOE_IMPL_MASK) != 8'h00
                                 |=> (8'(flags_r) & 8'($past(set_ev)) & `UOE_IMPL_MASK)
                                     == (8'($past(set_ev)) & `UOE_IMPL_MASK))
        else $error("Clear won over a same-cycle set");

    bus_answer_a: assert property (bus_req |-> ##[0:1] !avm_waitrequest)
        else $error("Bus request not answered within one wait cycle");

    irq_level_a: assert property ($rose(irq) |-> $past(8'(flags_nxt) & mask_r) != 8'h00 || $past(wr_mask))
        else $error("Interrupt rose without an unmasked flag");

    ////////////////////////////////////////////////////////////////////////
    // Checker helpers; both saturate, so a lost event cannot wrap and hide

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_gap_r <= '0;
        end else if (tick_pulse) begin
            tick_gap_r <= '0;
        end else if (tick_gap_r != MS_LAST) begin
            tick_gap_r <= tick_gap_r + `UOE_CNT_W'(1);
        end
    end

    // Held time taken from the synchroniser history, not from the detector
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            line_held_r <= '0;
        end else if ({prev_r.dp, prev_r.dm} != line_now) begin
            line_held_r <= '0;
        end else if (line_held_r != MS_LAST) begin
            line_held_r <= line_held_r + `UOE_CNT_W'(1);
        end
    end

    tick_not_early_a: assert property (tick_pulse |-> tick_gap_r == MS_LAST)
        else $error("Timer expired before a full interval");

    tick_not_late_a: assert property (tick_gap_r == MS_LAST |-> tick_pulse)
        else $error("Timer missed its expiry");

    line_held_full_a: assert property (line_ev |-> line_held_r == MS_LAST - `UOE_CNT_W'(1))
        else $error("Line event before a full stable interval");

    line_once_a: assert property (line_ev |=> !line_ev [*8])
        else $error("Line event repeated for one stable state");

    line_record_a: assert property (line_ev |=> line_stable_r == $past(line_cand_r))
        else $error("New stable line state not recorded");

    act_awake_quiet_a: assert property (!sleep_en |-> !set_ev.act)
        else $error("Activity event while awake");

    sesvd_with_end_a: assert property (set_ev.sesvd |-> set_ev.sesend)
        else $error("Session end drop without a comparator change");

    sesvd_not_fall_a: assert property ($fell(sync2_r.sess_end) && !flags_r.sesvd |=> !flags_r.sesvd)
        else $error("Comparator fall set the session end drop flag");

    flag_rise_cause_a: assert property ((8'(flags_nxt) & ~8'(flags_r) & ~8'(set_ev)) == 8'h00)
        else $error("Flag set without a hardware event");

    flags_sticky_a: assert property (!wr_status
                                     |=> (8'(flags_r) & 8'($past(flags_r))) == 8'($past(flags_r)))
        else $error("Flag dropped without a clear");

    zero_write_keeps_a: assert property (wr_status && avm_req.writedata[7:0] == 8'h00
                                         |=> (8'(flags_r) & 8'($past(flags_r))) == 8'($past(flags_r)))
        else $error("Writing zero dropped a flag");

    rsvd_bit_zero_a: assert property (!flags_r.rsvd && !mask_r[1])
        else $error("Unimplemented bit 1 became set");

    read_status_data_a: assert property (bus_acc && avm_req.read
                                         && addr_hit(avm_req.address, `UOE_STATUS_OFS)
                                         |-> avm_readdata == {24'h00_0000, 8'($past(flags_r)) & `UOE_IMPL_MASK})
        else $error("Status read returned wrong data");

    readdata_hold_a: assert property (!(avm_req.read && bus_state_r == UOE_IDLE) |=> $stable(avm_readdata))
        else $error("Read data changed outside a read");

    irq_drop_a: assert property ($fell(irq) |-> $past(wr_status || wr_mask))
        else $error("Interrupt dropped without a register write");

    mask_write_only_a: assert property (!wr_mask |=> $stable(mask_r))
        else $error("Mask changed without a mask write");

endmodule : uoe_event_flags

//--- uoe_xcvr_model.sv
// Transceiver, ID pin and VBUS comparator levels seen by the OTG event flags.
// Assumes the bench calls drive() between transfers; one clock domain only.
module uoe_xcvr_model
    import uoe_pkg::*;
(
    input  wire logic clk,
    output uoe_pins_t pins
);
    timeunit 1ns;
    timeprecision 1ps;
    initial pins = '0;

    // Levels move just after an edge, so the synchronisers see a clean change
    task automatic drive(input uoe_pins_t v);
        @(posedge clk);
        pins <= v;
    endtask : drive
endmodule : uoe_xcvr_model

//--- tb_top.sv
// Self-checking bench for the OTG event flag block.
// Assumes uoe_pkg, uoe_map.svh and uoe_xcvr_model are compiled first.
`include "uoe_map.svh"
module tb_top
    import uoe_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // Short count keeps timer and line stability tests brief
    localparam int          MS  = 20;
    localparam logic [3:0]  ST  = `UOE_STATUS_OFS;
    localparam logic [3:0]  MK  = `UOE_MASK_OFS;
    // Timer flag runs free, so most reads hide bit 6
    localparam logic [31:0] NT  = 32'hFFFFFFBF;
    localparam logic [31:0] ALL = 32'hFFFFFFFF;
    logic         clk;
    logic         rst_n;
    logic         sleep_en;
    uoe_avm_req_t avm_req;
    logic [31:0]  avm_readdata;
    logic         avm_waitrequest;
    logic         irq;
    uoe_pins_t    pins;
    logic [31:0]  rd;
    int           n_fail;
    int           n_checks;

    initial clk = 1'b0;
    always #2 clk = ~clk;

    uoe_event_flags #(.MS_CYCLES(MS)) uoe_event_flags_inst (
        .clk(clk), .rst_n(rst_n), .pins(pins), .sleep_en(sleep_en), .avm_req(avm_req),
        .avm_readdata(avm_readdata), .avm_waitrequest(avm_waitrequest), .irq(irq)
    );
    uoe_xcvr_model uoe_xcvr_model_inst (.clk(clk), .pins(pins));

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk32(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : chk32

    task automatic chk1(input string name, input logic exp);
        @(negedge clk);
        n_checks++;
        if (irq !== exp) begin
            n_fail++;
            $display("BAD %s expected %b seen %b", name, exp, irq);
        end
    endtask : chk1

    // Request stands until waitrequest is seen low at a rising edge; data is taken there
    task automatic bus_op(input logic wr_en, input logic [3:0] a, input logic [31:0] d,
                          input logic [3:0] be, output logic [31:0] got);
        int   n;
        logic done;
        n = 0;
        done = 1'b0;
        @(posedge clk);
        avm_req <= '{address: a, read: !wr_en, write: wr_en, writedata: d, byteenable: be};
        do begin
            @(posedge clk);
            n++;
            done = (avm_waitrequest === 1'b0);
        end while (!done && n < 50);
        got = avm_readdata;
        avm_req <= '0;
        if (!done) begin
            n_fail++;
            $display("BAD bus answer expected 0 seen 1");
            report_and_stop();
        end
    endtask : bus_op

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        bus_op(1'b1, a, d, 4'hF, rd);
    endtask : wr

    task automatic rd_chk(input string name, input logic [3:0] a, input logic [31:0] keep,
                          input logic [31:0] exp);
        bus_op(1'b0, a, 32'h0, 4'hF, rd);
        chk32(name, exp, rd & keep);
    endtask : rd_chk

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : report_and_stop

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        $display("watchdog expired");
        report_and_stop();
    end

    initial begin
        n_fail = 0;
        n_checks = 0;
        sleep_en = 1'b0;
        avm_req = '0;
        rst_n = 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        rd_chk("status reset", ST, ALL, 32'h0);
        rd_chk("mask reset", MK, ALL, 32'h0);
        $display("test reset done");
        wr(ST, 32'h40);
        repeat (MS + 4) @(posedge clk);
        rd_chk("tick", ST, 32'h40, 32'h40);
        $display("test timer done");
        wr(ST, 32'hFF);
        uoe_xcvr_model_inst.drive(5'h10);
        repeat (6) @(posedge clk);
        rd_chk("id change", ST, NT, 32'h80);
        bus_op(1'b1, ST, 32'h80, 4'h0, rd);
        wr(ST, 32'h00);
        rd_chk("id kept", ST, NT, 32'h80);
        wr(ST, 32'hFFFFFF80);
        rd_chk("id cleared", ST, NT, 32'h0);
        $display("test id done");
        uoe_xcvr_model_inst.drive(5'h12);
        repeat (6) @(posedge clk);
        rd_chk("sess valid", ST, NT, 32'h01);
        wr(ST, 32'hFF);
        uoe_xcvr_model_inst.drive(5'h13);
        repeat (6) @(posedge clk);
        rd_chk("sess end rise", ST, NT, 32'h0C);
        wr(ST, 32'hFF);
        uoe_xcvr_model_inst.drive(5'h12);
        repeat (6) @(posedge clk);
        rd_chk("sess end fall", ST, NT, 32'h04);
        $display("test vbus done");
        wr(ST, 32'hFF);
        uoe_xcvr_model_inst.drive(5'h1A);
        repeat (MS / 2) @(posedge clk);
        rd_chk("line early", ST, NT, 32'h0);
        repeat (MS + 4) @(posedge clk);
        rd_chk("line stable", ST, NT, 32'h20);
        wr(ST, 32'hFF);
        repeat (MS + 4) @(posedge clk);
        rd_chk("line once", ST, NT, 32'h0);
        $display("test line done");
        sleep_en <= 1'b1;
        uoe_xcvr_model_inst.drive(5'h0A);
        repeat (6) @(posedge clk);
        rd_chk("activity", ST, NT, 32'h90);
        bus_op(1'b1, ST, 32'hFF, 4'hE, rd);
        rd_chk("upper lanes", ST, NT, 32'h90);
        wr(ST, 32'hFF);
        uoe_xcvr_model_inst.drive(5'h0E);
        repeat (6) @(posedge clk);
        rd_chk("activity dm", 4'h2, NT, 32'h10);
        sleep_en <= 1'b0;
        $display("test activity done");
        wr(MK, ALL);
        rd_chk("mask bits", MK, ALL, 32'hFD);
        wr(MK, 32'h80);
        wr(ST, 32'hFF);
        chk1("irq idle", 1'b0);
        uoe_xcvr_model_inst.drive(5'h1A);
        repeat (6) @(posedge clk);
        chk1("irq raised", 1'b1);
        wr(ST, 32'h80);
        chk1("irq cleared", 1'b0);
        wr(4'h8, 32'hFF);
        rd_chk("unmapped", 4'h8, ALL, 32'h0);
        $display("test irq done");
        report_and_stop();
    end
endmodule : tb_top
